// ---- inc/mmd_defines.svh ----
// constants for the memory map decoder: addresses, field positions, resets
// assumes inclusion by the design modules only
// Overview of operation
// [RULE1] data flash appears in xdata from 0400h
// [RULE2] program flash shrinks from top by partition
// [RULE3] data flash windows per partition code
// [RULE4] xdata reads reach both partitions; writes by select
// [RULE5] no instruction fetch from data flash
// [RULE6] program lock blocks program writes, not data
// [RULE7] 128 config bytes; user mode read only
// [RULE8] serial mode writes only 8000h-803Fh
// [RULE9] 16-bit config address serial, 8-bit user
// [RULE10] hw config registers at 803Fh, 803Eh, 803Dh
// [RULE11] security bit clear blocks config writes until erase
// [RULE12] serial number and trim byte never alterable
// [RULE13] direct low RAM, direct high SFR, indirect upper RAM
// [RULE14] RAM 20h-2Fh bit addressable, 128 bits
// [RULE15] SFR bit access only at x0h/x8h
// [RULE16] four register banks chosen by status word
// [RULE17] stack pointer resets 07h, pre-increment push
// [RULE18] first fetch after reset at 0000h
// [RULE19] boot ROM at F800h-FFFFh when enabled; in user mode the code fetches only F800h-FBFFh
// [RULE20] boot entry points F802, F805, FBE6
// [RULE21] unimplemented SFR reads return zero
// [RULE22] 64-byte pages erased before write
// [RULE23] data size field defaults 11, no data flash
// [RULE24] write-select bit steers xdata writes
// [RULE25] refused config writes complete silently, no stall
`ifndef MMD_DEFINES_SVH
`define MMD_DEFINES_SVH
// ------------
// flash map
// ------------
`define MMD_DATA_BASE      16'h0400
`define MMD_DATA_END_00    16'h13ff
`define MMD_DATA_END_01    16'h0bff
`define MMD_DATA_END_10    16'h07ff
`define MMD_PROG_END_00    16'h0fff
`define MMD_PROG_END_01    16'h17ff
`define MMD_PROG_END_10    16'h1bff
`define MMD_PROG_END_11    16'h1fff
`define MMD_PAGE_MASK      16'hffc0
`define MMD_BOOT_BASE      16'hf800
`define MMD_BOOT_USER_END  16'hfbff
`define MMD_BOOT_END       16'hffff
`define MMD_ENTRY_SFR_RD   16'hf802
`define MMD_ENTRY_SFR_WR   16'hf805
`define MMD_ENTRY_CFG_RD   16'hfbe6
`define MMD_RESET_VECTOR   16'h0000
// ------------
// configuration memory
// ------------
`define MMD_CFG_BASE       16'h8000
`define MMD_CFG_WR_END     16'h803f
`define MMD_CFG_END        16'h807f
`define MMD_CFG_HW_CONFIG_ZERO       7'h3f
`define MMD_HW_CONFIG_ZERO_RESET     8'hff
`define MMD_HW_CONFIG_ZERO_SECURE    7
`define MMD_HW_CONFIG_ZERO_PML       6
`define MMD_HW_CONFIG_ZERO_RSL       5
`define MMD_HW_CONFIG_ZERO_EBR       4
`define MMD_SECTOR_END     16'h0fff
// ------------
// register space
// ------------
`define MMD_SFR_SP         8'h81
`define MMD_SFR_MWS        8'h8f
`define MMD_SFR_PSW        8'hd0
`define MMD_SP_RESET       8'h07
`define MMD_BIT_RAM_BASE   8'h20
`define MMD_PSW_BANK_LO    3
`define MMD_ZERO8          8'h00
`endif

// ---- inc/mmd_pkg.sv ----
// types shared by the memory map decoder modules
// assumes mmd_defines.svh sits beside it
package mmd_pkg;
   typedef logic [7:0] mmd_byte_t;
endpackage

// ---- inc/mmd_ram_if.sv ----
// interface between the decoder and its scratchpad memory
// assumes one clock domain
interface mmd_ram_if;
   logic       we;     // write strobe
   logic [7:0] addr;   // byte address
   logic [7:0] wdata;  // write data
   logic [7:0] rdata;  // registered read data
   modport ctl (output we, addr, wdata, input rdata);
   modport mem (input we, addr, wdata, output rdata);
endinterface

// ---- rtl/mmd_cfg_mem.sv ----
// 128-byte configuration memory with registered read data
// assumes write permission already checked by the decoder
`include "mmd_defines.svh"
module mmd_cfg_mem
   import mmd_pkg::*;
(
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       arst_n,
   // access
   input  wire logic       we,
   input  wire logic [6:0] addr,
   input  wire logic [7:0] wdata,
   output logic      [7:0] rdata,
   // hardware config zero, always visible
   output logic      [7:0] hw_config_zero
);
   mmd_byte_t mem_q [128];  // config bytes

   // ------------
   // storage; hw_config_zero byte resets to its erased default
   // ------------
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         mem_q[`MMD_CFG_HW_CONFIG_ZERO] <= `MMD_HW_CONFIG_ZERO_RESET;
      end else if (we) begin
         mem_q[addr] <= wdata;
      end
   end

   always_ff @(posedge sys_clk) begin
      rdata <= mem_q[addr];
   end

   assign hw_config_zero = mem_q[`MMD_CFG_HW_CONFIG_ZERO];
endmodule // mmd_cfg_mem

// ---- rtl/mmd_decoder.sv ----
// memory map decoder: flash partition, config gate, register space
// assumes core presents one access per cycle, acknowledges appear a cycle later, read data a cycle after that
`include "mmd_defines.svh"
module mmd_decoder
   import mmd_pkg::*;
(
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        arst_n,
   // mode
   input  wire logic        serial_programming_mode,
   input  wire logic        mass_erase_done,
   // code fetch
   input  wire logic        fetch_req,
   input  wire logic [15:0] program_counter,
   // external data move
   input  wire logic        xdata_rd,
   input  wire logic        xdata_wr,
   input  wire logic [15:0] xdata_addr,
   input  wire logic        flash_erase,
   input  wire logic        page_erased,
   // configuration access
   input  wire logic        cfg_rd,
   input  wire logic        cfg_wr,
   input  wire logic [15:0] cfg_addr,
   input  wire logic [7:0]  cfg_wdata,
   // register space
   input  wire logic        reg_rd,
   input  wire logic        reg_wr,
   input  wire logic        reg_indirect,
   input  wire logic        reg_bit,
   input  wire logic        reg_rn,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        stack_push,
   input  wire logic        stack_pop,
   // results
   output logic             fetch_ok_q,
   output logic             fetch_boot_q,
   output logic [15:0]      reset_vector_q,
   output logic             flash_sel_q,
   output logic [15:0]      flash_addr_q,
   output logic             flash_we_q,
   output logic             flash_prog_space_q,
   output logic             cfg_done_q,
   output logic [7:0]       cfg_rdata_q,
   output logic             reg_done_q,
   output logic [7:0]       reg_rdata_q,
   output logic             bit_ok_q,
   output logic [7:0]       stack_ptr_q,
   output logic [1:0]       bank_q
);
   // ------------
   // storage
   // ------------
   mmd_ram_if   ram ();
   logic        cfg_we;
   logic [6:0]  cfg_idx;
   logic [7:0]  cfg_rdata;
   logic [7:0]  hw_config_zero;

   mmd_ram u_ram (.sys_clk(sys_clk), .ram(ram.mem));

   mmd_cfg_mem u_cfg (
      .sys_clk (sys_clk),
      .arst_n  (arst_n),
      .we      (cfg_we),
      .addr    (cfg_idx),
      .wdata   (cfg_wdata),
      .rdata   (cfg_rdata),
      .hw_config_zero    (hw_config_zero)
   );

   // ------------
   // functions
   // ------------
   function automatic logic in_rng(logic [15:0] a, logic [15:0] lo, logic [15:0] hi);
      return (a >= lo) && (a <= hi);
   endfunction

   // ------------
   // flash partition decode
   // ------------
   wire [1:0]  data_flash_size_field = hw_config_zero[1:0];  // erased default 11
   logic [15:0] prog_end;   // top of program partition
   logic [15:0] data_end;   // top of data partition
   always_comb begin
      unique case (data_flash_size_field)           // RULE2
         2'b00:   prog_end = `MMD_PROG_END_00;
         2'b01:   prog_end = `MMD_PROG_END_01;
         2'b10:   prog_end = `MMD_PROG_END_10;
         2'b11:   prog_end = `MMD_PROG_END_11;     // RULE23
      endcase
      unique case (data_flash_size_field)           // RULE3
         2'b00:   data_end = `MMD_DATA_END_00;
         2'b01:   data_end = `MMD_DATA_END_01;
         2'b10:   data_end = `MMD_DATA_END_10;
         2'b11:   data_end = `MMD_DATA_BASE;       // unused, no data flash
      endcase
   end
   wire has_data   = data_flash_size_field != 2'b11;   // RULE23
   // data flash sits after the program partition in the array
   wire [15:0] data_phys_base = prog_end + 16'h0001;
   wire in_data    = has_data
                   && in_rng(xdata_addr, `MMD_DATA_BASE, data_end);  // RULE1
   wire in_prog_x  = in_rng(xdata_addr, `MMD_DATA_BASE - `MMD_DATA_BASE, prog_end);
   wire [15:0] data_phys = data_phys_base + (xdata_addr - `MMD_DATA_BASE);

   // ------------
   // write-select and lock
   // ------------
   logic memory_write_select_q;  // flash_write_space_select bit
   wire  flash_write_space_select = memory_write_select_q;
   wire  pml = hw_config_zero[`MMD_HW_CONFIG_ZERO_PML];
   wire  rsl = hw_config_zero[`MMD_HW_CONFIG_ZERO_RSL];
   // locks apply in user mode only; data partition never locked
   wire  prog_locked = !serial_programming_mode
                     && (pml || (rsl && xdata_addr <= `MMD_SECTOR_END));   // RULE6
   wire  x_mod     = xdata_wr || flash_erase;
   // program-space write when select bit set, else data flash
   wire  x_prog    = flash_write_space_select ? in_prog_x : 1'b0;          // RULE24
   wire  x_data    = flash_write_space_select ? 1'b0 : in_data;            // RULE4
   wire  x_rd_hit  = in_data || in_prog_x;                                 // RULE4
   // a write lands only on a page already erased
   wire  wr_ok     = flash_erase || page_erased;                           // RULE22
   wire  x_we      = x_mod && wr_ok && (x_data || (x_prog && !prog_locked));
   wire [15:0] x_page = flash_erase ? (xdata_addr & `MMD_PAGE_MASK) : xdata_addr;

   // ------------
   // fetch decode
   // ------------
   wire boot_en   = hw_config_zero[`MMD_HW_CONFIG_ZERO_EBR];
   wire [15:0] boot_top = serial_programming_mode ? `MMD_BOOT_END : `MMD_BOOT_USER_END;
   wire f_boot    = boot_en && in_rng(program_counter, `MMD_BOOT_BASE, boot_top); // RULE19
   wire f_prog    = program_counter <= prog_end;                          // RULE5
   // entry points lie inside the boot window by construction
   wire f_entry   = (program_counter == `MMD_ENTRY_SFR_RD)
                 || (program_counter == `MMD_ENTRY_SFR_WR)
                 || (program_counter == `MMD_ENTRY_CFG_RD);               // RULE20

   // ------------
   // configuration gate
   // ------------
   // serial mode decodes 16 bits; user mode only the low byte
   wire cfg_in16  = in_rng(cfg_addr, `MMD_CFG_BASE, `MMD_CFG_END);        // RULE9
   assign cfg_idx = cfg_addr[6:0];
   wire cfg_hit   = serial_programming_mode ? cfg_in16 : (cfg_addr[7] == 1'b0); // RULE9
   wire cfg_lower = in_rng(cfg_addr, `MMD_CFG_BASE, `MMD_CFG_WR_END);     // RULE8
   logic unlocked_q;  // security cleared by mass erase
   wire secure_ok = hw_config_zero[`MMD_HW_CONFIG_ZERO_SECURE] || unlocked_q;                 // RULE11
   // upper half, serial number and trim lie above 803Fh, never written
   assign cfg_we  = cfg_wr && serial_programming_mode && cfg_lower
                 && secure_ok;                                            // RULE7 RULE8 RULE12
   // hcr registers live in the lower half at 3Fh, 3Eh, 3Dh      RULE10

   // ------------
   // register space decode
   // ------------
   wire  is_sfr   = !reg_indirect && reg_addr[7];                         // RULE13
   wire  sfr_bitok = (reg_addr[2:0] == 3'b000);                           // RULE15
   // bit number: low bits select bit, upper select byte
   wire [7:0] bit_byte = `MMD_BIT_RAM_BASE + {4'h0, reg_addr[6:3]};      // RULE14
   wire  bit_ok_d = reg_bit && (reg_addr[7] ? sfr_bitok : 1'b1);
   logic [7:0] psw_q;
   wire [1:0] bank_sel = psw_q[`MMD_PSW_BANK_LO+1:`MMD_PSW_BANK_LO];
   wire [7:0] rn_addr  = {3'b000, bank_sel, reg_addr[2:0]};               // RULE16
   wire [7:0] sp_inc   = stack_ptr_q + 8'h01;
   wire [7:0] ram_a    = stack_push ? sp_inc :
                         stack_pop  ? stack_ptr_q :
                         reg_rn     ? rn_addr :
                         (reg_bit && !reg_addr[7]) ? bit_byte : reg_addr;
   wire  ram_wr   = (reg_wr && !is_sfr) || stack_push;
   assign ram.we    = ram_wr;
   assign ram.addr  = ram_a;
   assign ram.wdata = reg_wdata;

   logic [7:0] sfr_rd;
   always_comb begin
      unique case (reg_addr)
         `MMD_SFR_SP:  sfr_rd = stack_ptr_q;
         `MMD_SFR_PSW: sfr_rd = psw_q;
         `MMD_SFR_MWS: sfr_rd = {7'h00, memory_write_select_q};
         default:      sfr_rd = `MMD_ZERO8;                               // RULE21
      endcase
   end
   logic sfr_pend_q;   // read answer comes from sfr, not ram
   logic [7:0] sfr_hold_q;

   // ------------
   // sfr storage
   // ------------
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         stack_ptr_q <= `MMD_SP_RESET;                                    // RULE17
         psw_q <= `MMD_ZERO8;
         memory_write_select_q <= 1'b0;
      end else begin
         if (stack_push) stack_ptr_q <= sp_inc;                          // RULE17
         else if (stack_pop) stack_ptr_q <= stack_ptr_q - 8'h01;         // RULE17
         else if (reg_wr && is_sfr && reg_addr == `MMD_SFR_SP) stack_ptr_q <= reg_wdata;
         if (reg_wr && is_sfr && reg_addr == `MMD_SFR_PSW) psw_q <= reg_wdata;
         if (reg_wr && is_sfr && reg_addr == `MMD_SFR_MWS)
            memory_write_select_q <= reg_wdata[0];                        // RULE24
      end
   end

   // ------------
   // security latch and response registers
   // ------------
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         unlocked_q <= 1'b0;
      end else if (mass_erase_done) begin
         unlocked_q <= 1'b1;                                              // RULE11
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         fetch_ok_q <= 1'b0;
         fetch_boot_q <= 1'b0;
         reset_vector_q <= `MMD_RESET_VECTOR;                             // RULE18
         flash_sel_q <= 1'b0;
         flash_addr_q <= 16'h0000;
         flash_we_q <= 1'b0;
         flash_prog_space_q <= 1'b0;
         cfg_done_q <= 1'b0;
         reg_done_q <= 1'b0;
         bit_ok_q <= 1'b0;
         sfr_pend_q <= 1'b0;
         sfr_hold_q <= `MMD_ZERO8;
         bank_q <= 2'b00;
      end else begin
         fetch_ok_q <= fetch_req && (f_prog || f_boot || (f_entry && boot_en)); // RULE5
         fetch_boot_q <= fetch_req && f_boot;
         flash_sel_q <= (xdata_rd && x_rd_hit) || x_we;
         flash_addr_q <= (xdata_rd ? in_data : x_data) ? data_phys : x_page;
         flash_we_q <= x_we;
         flash_prog_space_q <= x_prog;
         // refused writes still finish in one cycle     RULE25
         cfg_done_q <= (cfg_rd && cfg_hit) || cfg_wr;
         reg_done_q <= reg_rd || reg_wr || stack_push || stack_pop;
         bit_ok_q <= bit_ok_d;
         sfr_pend_q <= is_sfr;
         sfr_hold_q <= sfr_rd;
         bank_q <= bank_sel;
      end
   end

   // ------------
   // read data outputs, registered
   // ------------
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         cfg_rdata_q <= `MMD_ZERO8;
         reg_rdata_q <= `MMD_ZERO8;
      end else begin
         cfg_rdata_q <= cfg_rdata;
         reg_rdata_q <= sfr_pend_q ? sfr_hold_q : ram.rdata;
      end
   end
endmodule // mmd_decoder

// ---- rtl/mmd_ram.sv ----
// 256-byte scratchpad memory with registered read data
// assumes addressing already resolved by the decoder
module mmd_ram
   import mmd_pkg::*;
(
   // clock, no reset
   input  wire logic sys_clk,
   // port
   mmd_ram_if.mem    ram
);
   mmd_byte_t mem_q [256];  // storage, no reset: plain RAM

   // ------------
   // write and registered read
   // ------------
   always_ff @(posedge sys_clk) begin
      if (ram.we) begin
         mem_q[ram.addr] <= ram.wdata;
      end
      ram.rdata <= mem_q[ram.addr];
   end
endmodule // mmd_ram

// ---- tb/memory_map_decoder_test.sv ----
// self-checking bench for the memory map decoder
// assumes the core model drives requests and this module drives mode lines
module memory_map_decoder_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        sys_clk, arst_n, serial_programming_mode, mass_erase_done, page_erased;
   logic        fetch_req, xdata_rd, xdata_wr, cfg_rd, cfg_wr, reg_rd, reg_wr;
   logic        stack_push, stack_pop, flash_erase, reg_indirect, reg_bit, reg_rn;
   logic [15:0] program_counter, xdata_addr, cfg_addr, reset_vector_q, flash_addr_q;
   logic [7:0]  reg_addr, cfg_wdata, reg_wdata, cfg_rdata_q, reg_rdata_q, stack_ptr_q;
   logic        fetch_ok_q, fetch_boot_q, flash_sel_q, flash_we_q, flash_prog_space_q;
   logic        cfg_done_q, reg_done_q, bit_ok_q;
   logic [1:0]  bank_q;
   logic [7:0]  v, w;
   int          error_cnt, comparisons;
   mmd_decoder dut_u (.*);
   mmd_core_model core_u (.*);
   // ------------
   // clock, watchdog, verdict
   // ------------
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   // whole run is near 180 cycles; a hang is cut well beyond that
   initial begin
      repeat (6000) @(posedge sys_clk);
      error_cnt++;
      print_verdict;
   end
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // register read, data lands one cycle after the acknowledge
   task automatic rr(input logic [7:0] a, input logic [2:0] q, input logic [7:0] e);
      core_u.go(5, {8'h00, a}, 8'h00, q);
      chk(reg_done_q, 1'b1);
      @(negedge sys_clk);
      chk(reg_rdata_q, e);
   endtask
   task automatic cr(input logic [15:0] a, output logic [7:0] d);
      core_u.go(3, a, 8'h00, 3'b000);
      chk(cfg_done_q, 1'b1);
      @(negedge sys_clk);
      d = cfg_rdata_q;
   endtask
   task automatic cw(input logic [15:0] a, input logic [7:0] d);
      core_u.go(4, a, d, 3'b000);
      chk(cfg_done_q, 1'b1);
   endtask
   // ------------
   // scenarios
   // ------------
   task automatic t_stack;
      chk(stack_ptr_q, 8'h07);
      chk(reset_vector_q, 16'h0000);
      rr(8'h81, 3'b000, 8'h07);
      core_u.go(7, 16'h0000, 8'h5a, 3'b000);
      chk(stack_ptr_q, 8'h08);
      rr(8'h08, 3'b100, 8'h5a);
      core_u.go(8, 16'h0000, 8'h00, 3'b000);
      chk(stack_ptr_q, 8'h07);
      $display("stack test done");
   endtask
   task automatic t_regs;
      logic [7:0] ba [8] = '{8'h1f, 8'h20, 8'h2f, 8'h30, 8'h88, 8'h89, 8'hd0, 8'hff};
      core_u.go(6, 16'h0030, 8'hc3, 3'b000);
      rr(8'h30, 3'b000, 8'hc3);
      core_u.go(6, 16'h0090, 8'ha6, 3'b100);
      rr(8'h90, 3'b100, 8'ha6);
      rr(8'h90, 3'b000, 8'h00);
      rr(8'h80, 3'b000, 8'h00);
      core_u.go(6, 16'h00d0, 8'h10, 3'b000);
      @(negedge sys_clk);
      chk(bank_q, 2'h2);
      core_u.go(6, 16'h0011, 8'h3c, 3'b000);
      rr(8'h01, 3'b001, 8'h3c);
      foreach (ba[i]) begin
         core_u.go(5, {8'h00, ba[i]}, 8'h00, 3'b010);
         chk(bit_ok_q, ba[i][7] ? ba[i][2:0] == 3'h0 : 1'b1);
      end
      $display("register test done");
   endtask
   task automatic t_fetch;
      logic [15:0] pc [8] = '{16'h0000, 16'h1fff, 16'h2000, 16'hf800, 16'hf802, 16'hf805,
                              16'hfbe6, 16'hfc00};
      foreach (pc[i]) begin
         core_u.go(0, pc[i], 8'h00, 3'b000);
         if (i < 3) chk(fetch_ok_q, i < 2);
         chk(fetch_boot_q, i inside {[3:6]});
      end
      $display("fetch test done");
   endtask
   task automatic t_part;
      logic [15:0] pe [3] = '{16'h0fff, 16'h17ff, 16'h1bff};
      logic [15:0] de [3] = '{16'h13ff, 16'h0bff, 16'h07ff};
      serial_programming_mode = 1'b1;
      for (int c = 0; c < 3; c++) begin
         cw(16'h803f, {6'h3f, 2'(c)});
         cr(16'h803f, v);
         chk(v, {6'h3f, 2'(c)});
         core_u.go(0, pe[c], 8'h00, 3'b000);
         chk(fetch_ok_q, 1'b1);
         core_u.go(0, pe[c] + 16'h0001, 8'h00, 3'b000);
         chk(fetch_ok_q, 1'b0);
         core_u.go(1, 16'h0400, 8'h00, 3'b000);
         chk(flash_sel_q, 1'b1);
         chk(flash_addr_q, pe[c] + 16'h0001);
         core_u.go(1, de[c], 8'h00, 3'b000);
         chk(flash_addr_q, pe[c] + 16'h0001 + de[c] - 16'h0400);
      end
      $display("partition test done");
   endtask
   task automatic t_cfg;
      logic [15:0] ro [4] = '{16'h8040, 16'h8050, 16'h8054, 16'h807f};
      cw(16'h8000, 8'ha5);
      cr(16'h8000, v);
      chk(v, 8'ha5);
      foreach (ro[i]) begin
         cw(ro[i], 8'h5a);
         cr(ro[i], w);
         chk(w === 8'h5a, 1'b0);
      end
      cw(16'h803f, 8'h7e);
      cw(16'h8000, 8'h3c);
      cr(16'h8000, w);
      chk(w, 8'ha5);
      mass_erase_done = 1'b1;
      @(negedge sys_clk);
      mass_erase_done = 1'b0;
      cw(16'h8000, 8'h3c);
      cr(16'h8000, w);
      chk(w, 8'h3c);
      cw(16'h803f, 8'hfe);
      serial_programming_mode = 1'b0;
      cw(16'h8000, 8'h5a);
      cr(16'h0000, v);
      chk(v, 8'h3c);
      cr(16'h003f, v);
      chk(v, 8'hfe);
      $display("config test done");
   endtask
   task automatic t_flash;
      core_u.go(6, 16'h008f, 8'h01, 3'b000);
      core_u.go(2, 16'h0100, 8'h11, 3'b000);
      chk(flash_we_q, 1'b0);
      core_u.go(6, 16'h008f, 8'h00, 3'b000);
      core_u.go(2, 16'h0400, 8'h22, 3'b000);
      chk(flash_we_q, 1'b1);
      chk(flash_prog_space_q, 1'b0);
      page_erased = 1'b0;
      core_u.go(2, 16'h0400, 8'h33, 3'b000);
      chk(flash_we_q, 1'b0);
      page_erased = 1'b1;
      core_u.go(1, 16'h0100, 8'h00, 3'b000);
      chk(flash_sel_q, 1'b1);
      serial_programming_mode = 1'b1;
      cw(16'h803f, 8'h9e);
      serial_programming_mode = 1'b0;
      core_u.go(6, 16'h008f, 8'h01, 3'b000);
      core_u.go(2, 16'h0100, 8'h44, 3'b000);
      chk(flash_we_q, 1'b1);
      chk(flash_prog_space_q, 1'b1);
      $display("flash test done");
   endtask
   // ------------
   // main sequence
   // ------------
   initial begin
      arst_n = 1'b0;
      serial_programming_mode = 1'b0;
      mass_erase_done = 1'b0;
      page_erased = 1'b1;
      repeat (10) @(negedge sys_clk);
      arst_n = 1'b1;
      t_stack;
      t_regs;
      t_fetch;
      t_part;
      t_cfg;
      t_flash;
      print_verdict;
   end
endmodule // memory_map_decoder_test
bind mmd_decoder mmd_checker chk_u (.*);

// ---- tb/mmd_checker.sv ----
// assertion checker for the memory map decoder, bound to its top ports
// assumes one clock domain, registered acknowledges one cycle after a request and read data one cycle after that
module mmd_checker (
   // clock and reset
   input wire logic        sys_clk,
   input wire logic        arst_n,
   // requests
   input wire logic        fetch_req,
   input wire logic [15:0] program_counter,
   input wire logic        xdata_wr,
   input wire logic        page_erased,
   input wire logic        cfg_rd,
   input wire logic        cfg_wr,
   input wire logic        reg_rd,
   input wire logic        reg_wr,
   input wire logic        reg_indirect,
   input wire logic        reg_bit,
   input wire logic [7:0]  reg_addr,
   input wire logic        stack_push,
   input wire logic        stack_pop,
   // results
   input wire logic        fetch_ok_q,
   input wire logic [15:0] reset_vector_q,
   input wire logic        flash_we_q,
   input wire logic        cfg_done_q,
   input wire logic        reg_done_q,
   input wire logic [7:0]  reg_rdata_q,
   input wire logic        bit_ok_q,
   input wire logic [7:0]  stack_ptr_q,
   input wire logic [1:0]  bank_q
);
   // ------------
   // shared clocking
   // ------------
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   // any register access, byte or bit
   sequence s_reg_req;
      reg_rd || reg_wr;
   endsequence
   // direct read of an empty register slot, then its acknowledge
   sequence s_sfr_hole;
      reg_rd && !reg_indirect && !reg_bit && reg_addr == 8'h80 ##1 reg_done_q;
   endsequence
   // no write that could move the bank select
   sequence s_no_psw;
      !(reg_wr && (reg_bit || (!reg_indirect && reg_addr == 8'hd0)));
   endsequence

   property p_reg_done;
      s_reg_req |=> reg_done_q;
   endproperty
   a_reg_done: assert property (p_reg_done) else $error("register access not acknowledged");
   property p_sfr_zero;
      s_sfr_hole |=> reg_rdata_q == 8'h00;
   endproperty
   a_sfr_zero: assert property (p_sfr_zero) else $error("empty register slot not zero");
   property p_cfg_done;
      cfg_rd || cfg_wr |=> cfg_done_q;
   endproperty
   a_cfg_done: assert property (p_cfg_done) else $error("config access stalled");
   // pre-increment and decrement, nothing else competing
   property p_push;
      stack_push && !stack_pop && !reg_wr |=> stack_ptr_q == $past(stack_ptr_q) + 8'h01;
   endproperty
   a_push: assert property (p_push) else $error("push did not increment");
   property p_pop;
      stack_pop && !stack_push && !reg_wr |=> stack_ptr_q == $past(stack_ptr_q) - 8'h01;
   endproperty
   a_pop: assert property (p_pop) else $error("pop did not decrement");
   property p_vector;
      reset_vector_q == 16'h0000;
   endproperty
   a_vector: assert property (p_vector) else $error("reset vector moved");
   property p_sfr_bit;
      reg_bit && (reg_rd || reg_wr) && reg_addr[7] && reg_addr[2:0] != 3'h0 |=> !bit_ok_q;
   endproperty
   a_sfr_bit: assert property (p_sfr_bit) else $error("bit access granted off column");
   // above every program partition and below the boot window
   property p_no_data_exec;
      fetch_req && program_counter >= 16'h2000 && program_counter < 16'hf800 |=> !fetch_ok_q;
   endproperty
   a_no_data_exec: assert property (p_no_data_exec) else $error("fetch outside code");
   property p_erase_first;
      xdata_wr && !page_erased |=> !flash_we_q;
   endproperty
   a_erase_first: assert property (p_erase_first) else $error("write to unerased page");
   // two quiet cycles cover a one or two stage bank update
   property p_bank_hold;
      s_no_psw ##1 s_no_psw |=> $stable(bank_q);
   endproperty
   a_bank_hold: assert property (p_bank_hold) else $error("bank moved without write");
endmodule // mmd_checker

// ---- tb/mmd_core_model.sv ----
// processor core stand-in: issues one access at a time to the decoder
// assumes the decoder samples requests on the rising edge of sys_clk
module mmd_core_model (
   // clock
   input  wire logic   sys_clk,
   // request strobes
   output logic        fetch_req, xdata_rd, xdata_wr, cfg_rd, cfg_wr,
   output logic        reg_rd, reg_wr, stack_push, stack_pop, flash_erase,
   // qualifiers
   output logic        reg_indirect, reg_bit, reg_rn,
   // address and data
   output logic [15:0] program_counter, xdata_addr, cfg_addr,
   output logic [7:0]  reg_addr, cfg_wdata, reg_wdata
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------
   // idle state
   // ------------
   initial begin
      {fetch_req, xdata_rd, xdata_wr, cfg_rd, cfg_wr} = '0;
      {reg_rd, reg_wr, stack_push, stack_pop, flash_erase} = '0;
      {reg_indirect, reg_bit, reg_rn} = '0;
      {program_counter, xdata_addr, cfg_addr} = '0;
      {reg_addr, cfg_wdata, reg_wdata} = '0;
   end
   // one access: 0 fetch, 1 xrd, 2 xwr, 3 crd, 4 cwr, 5 rrd, 6 rwr, 7 push, 8 pop
   // returns at the falling edge after the taking edge
   task automatic go(input int k, input logic [15:0] a, input logic [7:0] d,
                     input logic [2:0] q);
      @(negedge sys_clk);
      {fetch_req, xdata_rd, xdata_wr, cfg_rd, cfg_wr, reg_rd, reg_wr, stack_push,
       stack_pop} <= 9'(9'h100 >> k);
      {program_counter, xdata_addr, cfg_addr} <= {3{a}};
      {reg_addr, cfg_wdata, reg_wdata} <= {a[7:0], d, d};
      {reg_indirect, reg_bit, reg_rn} <= q;
      @(posedge sys_clk);
      @(negedge sys_clk);
      {fetch_req, xdata_rd, xdata_wr, cfg_rd, cfg_wr, reg_rd, reg_wr, stack_push,
       stack_pop} <= '0;
      // released lines show the inverse, so a stale copy cannot pass
      {program_counter, xdata_addr, cfg_addr} <= ~{3{a}};
      {reg_addr, cfg_wdata, reg_wdata} <= ~{a[7:0], d, d};
   endtask
endmodule // mmd_core_model
